// file: verilog/swda_pkg.sv
// Constants of the watchdog and alarm block
// Behaviour
// - Refresh self-watchdog each 5 ms; reset after 210 ms
// - After self-reset reload all flash configuration
// - After self-reset set status flags, alert
// - Failed memory check: inert, both faults driven
// - Alarms active-low open-drain from per-channel masks
// - Enabled channels ORed onto each alarm
// - Alarm latched until clear pin low or bit
// - Report live alarm states in vendor status
// - Global channel fault pulls its group fault pin
// - External fault shuts globals unless masked, retries
// - Report live fault pin levels in vendor status
// - Fault pins low from reset until monitoring
// - Monitor disable low freezes checks and states
// - Ignore monitor disable while faulted or not good
// - Dependent mode starts only after primary good
// - Primary good loss in dependent mode halts watchdog, releases output, except in the manual reset low phase
// - Independent mode starts startup interval once monitoring has begun
// - First strobe edge or kick arms; edges or kick restart
// - Manual reset: debounce 200 ms, drive low, restart
// - Pin still low: wait 20 ms high first
package swda_pkg;

    // ********
    // Timing
    // ********
    localparam int CLK_MHZ = 250;
    localparam int SELF_REFRESH_MS = 5;
    localparam int SELF_LIMIT_MS = 210;
    localparam int MR_DEBOUNCE_MS = 200;
    localparam int RELEASE_DEBOUNCE_MS = 20;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int SELF_REFRESH_CYC = SELF_REFRESH_MS * CYC_PER_MS;
    localparam int SELF_LIMIT_CYC = SELF_LIMIT_MS * CYC_PER_MS;
    localparam int MR_DEBOUNCE_CYC = MR_DEBOUNCE_MS * CYC_PER_MS;
    localparam int RELEASE_DEBOUNCE_CYC = RELEASE_DEBOUNCE_MS * CYC_PER_MS;

    // ********
    // Widths and field positions
    // ********
    localparam int NCH = 12;
    localparam int CNT_W = 32;
    localparam int FIELD_W = 4;
    localparam logic [7:0] PAGE_ALL = 8'hff;
    // Vendor status bit positions
    localparam int VS_ALARM_A = 0;
    localparam int VS_ALARM_B = 1;
    localparam int VS_FAULT_IN = 2;
    localparam int VS_SECONDARY_FAULT_PIN_IN = 3;
    localparam int VS_WDOG_INT = 4;
    localparam int VS_W = 8;
    // Mode bits
    localparam int MODE_ALARM_CLEAR_BIT = 0;
    localparam int MODE_FAULT_IGN = 1;
    localparam int MODE_SECONDARY_FAULT_PIN_IGN = 2;
    localparam int MODE_ALERT_EN = 3;
    localparam int MODE_W = 4;
    // Per-channel fault action bits
    localparam int FA_ALARM_A = 0;
    localparam int FA_ALARM_B = 1;
    localparam int FA_GLOBAL = 2;
    localparam int FA_GROUP2 = 3;
    localparam int FA_W = 4;

    // External watchdog states, one-hot
    typedef enum logic [4:0] {
        SWDA_WD_IDLE = 5'h01,
        SWDA_WD_START = 5'h02,
        SWDA_WD_RUN = 5'h04,
        SWDA_WD_MRLOW = 5'h08,
        SWDA_WD_MRWAIT = 5'h10
    } swda_wd_t;

endpackage

// file: verilog/swda_timer.sv
// Loadable down-counter with a done flag
`timescale 1ns/1ps
module swda_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic load,
    input wire logic [31:0] load_val,
    input wire logic run,
    // Status
    output logic done
);
    // ********
    // Counter
    // ********
    logic [31:0] cnt_r; // Remaining cycles
    logic [31:0] cnt_nxt;

    // Next count: load wins, else count while running
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = load_val;
        end else if (run && cnt_r != 32'h0) begin
            cnt_nxt = cnt_r - 32'h1;
        end
    end

    // Register the count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done = (cnt_r == 32'h0);
endmodule

// file: verilog/swda_debounce.sv
// Pin level debounce over a set cycle count
`timescale 1ns/1ps
module swda_debounce (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pin and settings
    input wire logic pin,
    input wire logic [31:0] hold_cyc,
    // Stable level
    output logic level
);
    // ********
    // Stability counter
    // ********
    logic [31:0] cnt_r; // Cycles pin has differed from level
    logic [31:0] cnt_nxt;
    logic level_r; // Debounced level
    logic level_nxt;

    // Count while the pin differs; flip once it held long enough
    always_comb begin
        cnt_nxt = 32'h0;
        level_nxt = level_r;
        if (pin != level_r) begin
            if (cnt_r + 32'h1 >= hold_cyc) begin
                level_nxt = pin;
            end else begin
                cnt_nxt = cnt_r + 32'h1;
            end
        end
    end

    // Register, idle level high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 32'h0;
            level_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
endmodule

// file: verilog/swda_top.sv
// Watchdog, alarm and fault-pin logic
`timescale 1ns/1ps
module swda_top #(
    parameter logic [31:0] SELF_REFRESH_CYC = swda_pkg::SELF_REFRESH_CYC,
    parameter logic [31:0] SELF_LIMIT_CYC = swda_pkg::SELF_LIMIT_CYC,
    parameter logic [31:0] MR_DEBOUNCE_CYC = swda_pkg::MR_DEBOUNCE_CYC,
    parameter logic [31:0] RELEASE_DEBOUNCE_CYC = swda_pkg::RELEASE_DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Core liveness and memory check
    input wire logic core_refresh,
    input wire logic nvm_check_done,
    input wire logic nvm_check_ok,
    input wire logic monitor_start,
    output logic self_reset_req,
    output logic config_reload,
    // Per-channel events and configuration
    input wire logic [11:0] chan_event,
    input wire logic [47:0] fault_action_config,
    // Mode and page
    input wire logic [3:0] mode_config_reg,
    input wire logic [7:0] page_sel,
    // Alarm pins, open drain
    input wire logic alarm_clear_pin,
    output logic alarm_out_a_o,
    output logic alarm_out_a_oe,
    output logic alarm_out_b_o,
    output logic alarm_out_b_oe,
    // Fault pins, open drain two-way
    input wire logic primary_fault_pin_i,
    output logic primary_fault_pin_o,
    output logic primary_fault_pin_oe,
    input wire logic secondary_fault_pin_i,
    output logic secondary_fault_pin_o,
    output logic secondary_fault_pin_oe,
    output logic global_shutdown,
    // Monitoring control
    input wire logic monitor_disable_n,
    input wire logic power_good_out,
    input wire logic secondary_power_good,
    output logic monitor_active,
    // Status
    output logic [7:0] vendor_status_reg,
    output logic status_mfr_flag,
    output logic alert_n,
    // External watchdog
    input wire logic dependent_mode,
    input wire logic manual_reset_enable,
    input wire logic [31:0] wdog_startup_field,
    input wire logic [31:0] wdog_period_field,
    input wire logic wdog_soft_kick,
    input wire logic [31:0] good_delay_setting,
    input wire logic wdog_strobe_in,
    input wire logic wdog_out_n_i,
    output logic wdog_out_n_o,
    output logic wdog_out_n_oe
);
    // ********
    // Self-watchdog and memory check
    // ********
    logic [31:0] self_cnt_r; // Cycles since last core refresh
    logic [31:0] self_cnt_nxt;
    logic [31:0] tick_cnt_r; // Internal 5 ms refresh tick
    logic [31:0] tick_cnt_nxt;
    logic wdog_int_r; // Self-watchdog event occurred
    logic wdog_int_nxt;
    logic reload_r; // Reload request pulse
    logic reload_nxt;
    logic inert_r; // Memory check failed
    logic inert_nxt;
    logic mon_r; // Monitoring has begun
    logic mon_nxt;
    logic self_trip;

    // Core refresh every tick; timeout trips a self reset and reload
    always_comb begin
        tick_cnt_nxt = tick_cnt_r + 32'h1;
        self_cnt_nxt = self_cnt_r + 32'h1;
        if (tick_cnt_r + 32'h1 >= SELF_REFRESH_CYC) begin
            tick_cnt_nxt = 32'h0;
        end
        if (core_refresh && tick_cnt_r == 32'h0) begin
            self_cnt_nxt = 32'h0;
        end
        self_trip = (self_cnt_r + 32'h1 >= SELF_LIMIT_CYC);
        if (self_trip) begin
            self_cnt_nxt = 32'h0;
        end
        reload_nxt = self_trip;
        wdog_int_nxt = wdog_int_r | self_trip;
        inert_nxt = inert_r | (nvm_check_done & ~nvm_check_ok);
        mon_nxt = mon_r;
        if (self_trip) begin
            mon_nxt = 1'b0;
        end else if (monitor_start && !inert_r) begin
            mon_nxt = 1'b1;
        end
    end

    // Register self-watchdog state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_r <= 32'h0;
            self_cnt_r <= 32'h0;
            reload_r <= 1'b0;
            wdog_int_r <= 1'b0;
            inert_r <= 1'b0;
            mon_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            self_cnt_r <= self_cnt_nxt;
            reload_r <= reload_nxt;
            wdog_int_r <= wdog_int_nxt;
            inert_r <= inert_nxt;
            mon_r <= mon_nxt;
        end
    end

    assign self_reset_req = reload_r;
    assign config_reload = reload_r;
    assign status_mfr_flag = wdog_int_r;
    assign alert_n = ~(wdog_int_r & mode_config_reg[swda_pkg::MODE_ALERT_EN]);

    // ********
    // Monitoring disable and channel events
    // ********
    logic frozen_r; // Monitoring frozen
    logic frozen_nxt;
    logic [11:0] ev_r; // Effective channel events
    logic [11:0] ev_nxt;

    // Freeze only when good and fault-free; hold last event state
    always_comb begin
        frozen_nxt = 1'b0;
        if (mon_r && !monitor_disable_n && power_good_out && ev_r == 12'h0) begin
            frozen_nxt = 1'b1;
        end else if (frozen_r && !monitor_disable_n && power_good_out) begin
            frozen_nxt = 1'b1;
        end
        ev_nxt = frozen_r ? ev_r : (mon_r ? chan_event : 12'h0);
    end

    // Register monitoring state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frozen_r <= 1'b0;
            ev_r <= 12'h0;
        end else begin
            frozen_r <= frozen_nxt;
            ev_r <= ev_nxt;
        end
    end

    assign monitor_active = mon_r & ~frozen_r;

    // ********
    // Alarm latches and fault pins
    // ********
    logic [1:0] alarm_r; // Latched alarms, a then b
    logic [1:0] alarm_nxt;
    logic [1:0] alarm_set;
    logic [1:0] glob_set; // Global faults per group
    logic fault_in_s;
    logic secondary_fault_pin_in_s;

    // OR the enabled channels, latch, clear unless a set arrives
    always_comb begin
        alarm_set = 2'b00;
        glob_set = 2'b00;
        for (int i = 0; i < swda_pkg::NCH; i++) begin
            alarm_set[0] |= ev_r[i] & fault_action_config[i*4+swda_pkg::FA_ALARM_A];
            alarm_set[1] |= ev_r[i] & fault_action_config[i*4+swda_pkg::FA_ALARM_B];
            if (fault_action_config[i*4+swda_pkg::FA_GLOBAL] && ev_r[i]) begin
                glob_set[fault_action_config[i*4+swda_pkg::FA_GROUP2]] = 1'b1;
            end
        end
        alarm_nxt = alarm_r;
        if (!alarm_clear_pin || mode_config_reg[swda_pkg::MODE_ALARM_CLEAR_BIT]) begin
            alarm_nxt = 2'b00;
        end
        alarm_nxt = alarm_nxt | alarm_set;
    end

    // Register alarms
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alarm_r <= 2'b00;
        end else begin
            alarm_r <= alarm_nxt;
        end
    end

    // Open-drain drives; inert part floats all but the fault pins
    assign alarm_out_a_o = 1'b0;
    assign alarm_out_b_o = 1'b0;
    assign alarm_out_a_oe = alarm_r[0] & ~inert_r;
    assign alarm_out_b_oe = alarm_r[1] & ~inert_r;
    assign primary_fault_pin_o = 1'b0;
    assign secondary_fault_pin_o = 1'b0;
    assign primary_fault_pin_oe = inert_r | ~mon_r | glob_set[0];
    assign secondary_fault_pin_oe = inert_r | ~mon_r | glob_set[1];
    // External assertion shuts globals; release lets them retry
    assign fault_in_s = ~primary_fault_pin_i & ~primary_fault_pin_oe;
    assign secondary_fault_pin_in_s = ~secondary_fault_pin_i & ~secondary_fault_pin_oe;
    assign global_shutdown = mon_r & ((fault_in_s & ~mode_config_reg[swda_pkg::MODE_FAULT_IGN])
        | (secondary_fault_pin_in_s & ~mode_config_reg[swda_pkg::MODE_SECONDARY_FAULT_PIN_IGN]));

    // Vendor status only on the all-pages selector
    always_comb begin
        vendor_status_reg = 8'h00;
        if (page_sel == swda_pkg::PAGE_ALL) begin
            vendor_status_reg[swda_pkg::VS_ALARM_A] = alarm_out_a_oe;
            vendor_status_reg[swda_pkg::VS_ALARM_B] = alarm_out_b_oe;
            vendor_status_reg[swda_pkg::VS_FAULT_IN] = primary_fault_pin_i;
            vendor_status_reg[swda_pkg::VS_SECONDARY_FAULT_PIN_IN] = secondary_fault_pin_i;
            vendor_status_reg[swda_pkg::VS_WDOG_INT] = wdog_int_r;
        end
    end

    // ********
    // External watchdog
    // ********
    swda_pkg::swda_wd_t wd_r; // Watchdog state
    swda_pkg::swda_wd_t wd_nxt;
    logic strobe_r; // Previous strobe level
    logic kick_r; // Previous soft kick level
    logic wdo_r; // Watchdog output asserted
    logic wdo_nxt;
    logic armed_r; // First edge seen
    logic armed_nxt;
    logic mr_prev_r; // Previous debounced pin level
    logic t_load;
    logic [31:0] t_val;
    logic t_done;
    logic kick;
    logic mr_level;
    logic mr_fall;
    logic rel_level;
    logic start_ok;

    assign kick = (wdog_strobe_in & ~strobe_r) | (wdog_soft_kick & ~kick_r);
    assign start_ok = dependent_mode ? power_good_out : mon_r;
    assign mr_fall = manual_reset_enable & mr_prev_r & ~mr_level;

    // Next watchdog state and timer load
    always_comb begin
        wd_nxt = wd_r;
        wdo_nxt = wdo_r;
        armed_nxt = armed_r;
        t_load = 1'b0;
        t_val = wdog_period_field;
        if (dependent_mode && !power_good_out && wd_r != swda_pkg::SWDA_WD_MRLOW) begin
            wd_nxt = swda_pkg::SWDA_WD_IDLE;
            wdo_nxt = 1'b0;
            armed_nxt = 1'b0;
        end else if (mr_fall && wd_r != swda_pkg::SWDA_WD_MRLOW) begin
            wd_nxt = swda_pkg::SWDA_WD_MRLOW;
            wdo_nxt = 1'b1;
            t_load = 1'b1;
            t_val = good_delay_setting;
        end else begin
            unique case (wd_r)
                swda_pkg::SWDA_WD_IDLE: begin
                    if (start_ok) begin
                        wd_nxt = swda_pkg::SWDA_WD_START;
                        t_load = 1'b1;
                        t_val = wdog_startup_field;
                        armed_nxt = 1'b0;
                    end
                end
                swda_pkg::SWDA_WD_START: begin
                    if (kick) begin
                        wd_nxt = swda_pkg::SWDA_WD_RUN;
                        armed_nxt = 1'b1;
                        t_load = 1'b1;
                    end else if (t_done) begin
                        wdo_nxt = 1'b1;
                    end
                end
                swda_pkg::SWDA_WD_RUN: begin
                    if (kick) begin
                        t_load = 1'b1;
                        wdo_nxt = 1'b0;
                    end else if (t_done && armed_r) begin
                        wdo_nxt = 1'b1;
                    end
                end
                swda_pkg::SWDA_WD_MRLOW: begin
                    if (t_done) begin
                        wdo_nxt = 1'b0;
                        wd_nxt = swda_pkg::SWDA_WD_MRWAIT;
                    end
                end
                swda_pkg::SWDA_WD_MRWAIT: begin
                    if (rel_level) begin
                        wd_nxt = swda_pkg::SWDA_WD_IDLE;
                    end
                end
            endcase
        end
    end

    // Register watchdog state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wd_r <= swda_pkg::SWDA_WD_IDLE;
            wdo_r <= 1'b0;
            armed_r <= 1'b0;
            strobe_r <= 1'b0;
            kick_r <= 1'b0;
            mr_prev_r <= 1'b1;
        end else begin
            wd_r <= wd_nxt;
            wdo_r <= wdo_nxt;
            armed_r <= armed_nxt;
            strobe_r <= wdog_strobe_in;
            kick_r <= wdog_soft_kick;
            mr_prev_r <= mr_level;
        end
    end

    // Shared interval timer
    swda_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .load(t_load),
        .load_val(t_val),
        .run(1'b1),
        .done(t_done)
    );

    // Falling-edge qualification of the manual reset pin
    swda_debounce u_mr_db (
        .clk(clk),
        .rstn(rstn),
        .pin(wdog_out_n_i | wdo_r),
        .hold_cyc(MR_DEBOUNCE_CYC),
        .level(mr_level)
    );

    // High-level qualification before restart
    swda_debounce u_rel_db (
        .clk(clk),
        .rstn(rstn),
        .pin(wdog_out_n_i),
        .hold_cyc(RELEASE_DEBOUNCE_CYC),
        .level(rel_level)
    );

    assign wdog_out_n_o = 1'b0;
    assign wdog_out_n_oe = wdo_r & ~inert_r;
endmodule

// file: sim/swda_asserts.sv
// Port checker of the watchdog and alarm block
`timescale 1ns/1ps
module swda_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Watched inputs
    input wire logic nvm_check_done,
    input wire logic nvm_check_ok,
    input wire logic monitor_start,
    input wire logic [11:0] chan_event,
    input wire logic [47:0] fault_action_config,
    input wire logic [3:0] mode_config_reg,
    input wire logic [7:0] page_sel,
    input wire logic alarm_clear_pin,
    input wire logic primary_fault_pin_i,
    input wire logic power_good_out,
    input wire logic dependent_mode,
    input wire logic manual_reset_enable,
    // Watched outputs
    input wire logic self_reset_req,
    input wire logic config_reload,
    input wire logic alarm_out_a_oe,
    input wire logic alarm_out_b_oe,
    input wire logic primary_fault_pin_oe,
    input wire logic secondary_fault_pin_oe,
    input wire logic global_shutdown,
    input wire logic monitor_active,
    input wire logic [7:0] vendor_status_reg,
    input wire logic status_mfr_flag,
    input wire logic wdog_out_n_oe
);
    // ********
    // Helper logic
    // ********
    logic started_r; // Monitoring has been started once
    logic started_nxt;
    logic any_a; // Some event routed to alarm A
    // Next state and alarm A routing
    always_comb begin
        started_nxt = started_r | monitor_start;
        any_a = 1'b0;
        for (int i = 0; i < 12; i++) begin
            any_a = any_a | (chan_event[i] & fault_action_config[4*i]);
        end
    end
    // Register the start flag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            started_r <= 1'b0;
        end else begin
            started_r <= started_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Memory check failure seen
    sequence s_nvm_bad;
        nvm_check_done && !nvm_check_ok;
    endsequence
    // Primary good lost in dependent mode for two cycles
    sequence s_pg_lost;
        (dependent_mode && !power_good_out && !manual_reset_enable) [*2];
    endsequence
    // ********
    // Assertions
    // ********
    AST_FAULT_HELD: assert property (!started_r && !monitor_start |->
        primary_fault_pin_oe && secondary_fault_pin_oe) else $error("fault pins not held");
    AST_ALARM_SET: assert property (monitor_active && any_a |-> ##[1:2] alarm_out_a_oe)
        else $error("alarm A not raised");
    AST_ALARM_LATCH: assert property (alarm_out_a_oe && alarm_clear_pin &&
        $past(alarm_clear_pin) && !mode_config_reg[0] && !$past(mode_config_reg[0]) &&
        nvm_check_ok |=> alarm_out_a_oe) else $error("alarm A dropped");
    AST_PAGE_GATE: assert property (page_sel != 8'hff |-> vendor_status_reg == 8'h00)
        else $error("status outside page");
    AST_ALARM_STAT: assert property (page_sel == 8'hff && nvm_check_ok |->
        vendor_status_reg[1:0] == {alarm_out_b_oe, alarm_out_a_oe}) else $error("alarm status");
    AST_EXT_FAULT: assert property (!primary_fault_pin_i && !primary_fault_pin_oe &&
        !mode_config_reg[1] |-> ##[0:2] global_shutdown) else $error("no shutdown");
    AST_RELOAD: assert property (self_reset_req |-> config_reload)
        else $error("no reload");
    AST_MFR_FLAG: assert property (self_reset_req |=> status_mfr_flag)
        else $error("flag not set");
    AST_INERT: assert property (s_nvm_bad |-> ##2 (primary_fault_pin_oe &&
        secondary_fault_pin_oe && !alarm_out_a_oe && !alarm_out_b_oe && !wdog_out_n_oe))
        else $error("inert state wrong");
    AST_PG_HALT: assert property (s_pg_lost |-> !wdog_out_n_oe)
        else $error("watchdog output kept");
endmodule
bind swda_top swda_asserts chk_u (.*);

// file: sim/swda_host_model.sv
// Host and peer model on the far side
`timescale 1ns/1ps
module swda_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Requests from the bench
    input wire logic strobe_en,
    input wire logic mon_off_req,
    input wire logic peer_fault_req,
    // Lines towards the block
    output logic wdog_strobe_in,
    output logic monitor_disable_n,
    output logic peer_fault_oe
);
    int gap; // Cycles between strobe toggles
    // Strobe rises every six cycles while enabled
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap <= 0;
            wdog_strobe_in <= 1'b0;
            monitor_disable_n <= 1'b1;
            peer_fault_oe <= 1'b0;
        end else begin
            gap <= (gap == 2) ? 0 : gap + 1;
            if (strobe_en && gap == 2) begin
                wdog_strobe_in <= !wdog_strobe_in;
            end
            monitor_disable_n <= !mon_off_req;
            peer_fault_oe <= peer_fault_req;
        end
    end
endmodule

// file: sim/tb_top.sv
// Self-checking bench of the watchdog and alarm block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    // ********
    // Signals
    // ********
    logic clk = 1'b0, rstn = 1'b0, core_refresh = 1'b1, nvm_check_done = 1'b1;
    logic nvm_check_ok = 1'b1, monitor_start = 1'b0, alarm_clear_pin = 1'b1;
    logic power_good_out = 1'b1, secondary_power_good = 1'b0, dependent_mode = 1'b0;
    logic manual_reset_enable = 1'b0, wdog_soft_kick = 1'b0, strobe_en = 1'b1;
    logic mon_off_req = 1'b0, peer_fault_req = 1'b0, mr_low = 1'b0;
    logic [11:0] chan_event = 12'h000;
    logic [47:0] fault_action_config = 48'h0;
    logic [3:0] mode_config_reg = 4'h0;
    logic [7:0] page_sel = 8'hff;
    logic [31:0] wdog_startup_field = 32'h14, wdog_period_field = 32'h10;
    logic [31:0] good_delay_setting = 32'h28;
    logic primary_fault_pin_i, secondary_fault_pin_i, wdog_out_n_i, wdog_strobe_in;
    logic monitor_disable_n, peer_fault_oe, self_reset_req, config_reload, alarm_out_a_o;
    logic alarm_out_a_oe, alarm_out_b_o, alarm_out_b_oe, primary_fault_pin_o;
    logic primary_fault_pin_oe, secondary_fault_pin_o, secondary_fault_pin_oe;
    logic global_shutdown, monitor_active, status_mfr_flag, alert_n, wdog_out_n_o;
    logic wdog_out_n_oe;
    logic [7:0] vendor_status_reg;
    int err_total = 0, num_checks = 0, seed = 57, c, v, ea, eb, pulses = 0;
    // Open-drain wire levels
    assign primary_fault_pin_i = !(primary_fault_pin_oe | peer_fault_oe);
    assign secondary_fault_pin_i = !secondary_fault_pin_oe;
    assign wdog_out_n_i = !(wdog_out_n_oe | mr_low);
    swda_top #(.SELF_REFRESH_CYC(8), .SELF_LIMIT_CYC(40), .MR_DEBOUNCE_CYC(20),
        .RELEASE_DEBOUNCE_CYC(10)) dut_u (.*);
    swda_host_model host_u (.*);
    // Clock of 4 ns
    always #2 clk = ~clk;
    // Count self reset pulses
    always @(posedge clk) begin
        if (self_reset_req === 1'b1) pulses++;
    end
    // Wait n edges, then settle
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Verdict and end of run
    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog against hangs
    initial begin
        #100000;
        err_total++;
        end_sim;
    end
    // ********
    // Tests
    // ********
    initial begin
        wt(3);
        rstn <= 1'b1;
        wt(2);
        `CHK({primary_fault_pin_oe, secondary_fault_pin_oe}, 2'b11)
        monitor_start <= 1'b1;
        wt(4);
        `CHK(primary_fault_pin_oe, 1'b0)
        $display("test fault_hold done");
        for (int k = 0; k < 6; k++) begin
            c = $unsigned($random(seed)) % 12;
            v = $unsigned($random(seed)) % 4;
            ea = (v % 2) | (k >= 3);
            eb = v / 2;
            @(posedge clk);
            fault_action_config <= (48'(v) << (4*c)) | (48'h1 << (4*((c+5)%12)));
            @(posedge clk);
            chan_event <= (k >= 3) ? (12'h001 << c) | (12'h001 << ((c+5)%12)) : 12'h001 << c;
            @(posedge clk);
            chan_event <= 12'h000;
            wt(4);
            `CHK(alarm_out_a_oe, 1'(ea))
            `CHK(alarm_out_b_oe, 1'(eb))
            `CHK(vendor_status_reg[1:0], 2'({eb[0], ea[0]}))
            if (k % 2) alarm_clear_pin <= 1'b0;
            else mode_config_reg <= 4'h1;
            @(posedge clk);
            alarm_clear_pin <= 1'b1;
            mode_config_reg <= 4'h0;
            wt(3);
            `CHK({alarm_out_b_oe, alarm_out_a_oe}, 2'b00)
        end
        fault_action_config <= 48'h0;
        $display("test alarms done");
        peer_fault_req <= 1'b1;
        wt(5);
        `CHK(global_shutdown, 1'b1)
        `CHK(vendor_status_reg[2], 1'b0)
        mode_config_reg <= 4'h2;
        wt(3);
        `CHK(global_shutdown, 1'b0)
        peer_fault_req <= 1'b0;
        mode_config_reg <= 4'h0;
        wt(4);
        `CHK({global_shutdown, vendor_status_reg[3:2]}, 3'b011)
        page_sel <= 8'h03;
        wt(1);
        `CHK(vendor_status_reg, 8'h00)
        `CHK({alarm_out_a_o, alarm_out_b_o, wdog_out_n_o}, 3'h0)
        `CHK({primary_fault_pin_o, secondary_fault_pin_o}, 2'h0)
        page_sel <= 8'hff;
        $display("test fault_input done");
        mon_off_req <= 1'b1;
        wt(4);
        `CHK(monitor_active, 1'b0)
        power_good_out <= 1'b0;
        wt(4);
        `CHK(monitor_active, 1'b1)
        power_good_out <= 1'b1;
        mon_off_req <= 1'b0;
        $display("test monitor_off done");
        dependent_mode <= 1'b1;
        power_good_out <= 1'b0;
        strobe_en <= 1'b0;
        wt(40);
        `CHK(wdog_out_n_oe, 1'b0)
        power_good_out <= 1'b1;
        strobe_en <= 1'b1;
        wt(80);
        `CHK(wdog_out_n_oe, 1'b0)
        strobe_en <= 1'b0;
        wt(30);
        `CHK(wdog_out_n_oe, 1'b1)
        wdog_soft_kick <= 1'b1;
        wt(3);
        `CHK(wdog_out_n_oe, 1'b0)
        wt(30);
        power_good_out <= 1'b0;
        wt(3);
        `CHK(wdog_out_n_oe, 1'b0)
        $display("test ext_wdog done");
        power_good_out <= 1'b1;
        strobe_en <= 1'b1;
        manual_reset_enable <= 1'b1;
        wt(40);
        mr_low <= 1'b1;
        wt(10);
        `CHK(wdog_out_n_oe, 1'b0)
        wt(16);
        `CHK(wdog_out_n_oe, 1'b1)
        wt(45);
        `CHK(wdog_out_n_oe, 1'b0)
        mr_low <= 1'b0;
        wt(40);
        `CHK(wdog_out_n_oe, 1'b0)
        $display("test manual_reset done");
        `CHK(pulses, 0)
        mode_config_reg <= 4'h8;
        core_refresh <= 1'b0;
        wt(100);
        core_refresh <= 1'b1;
        `CHK(pulses > 0, 1'b1)
        `CHK({status_mfr_flag, vendor_status_reg[4], alert_n}, 3'b110)
        $display("test self_wdog done");
        fault_action_config <= 48'h0000_c000_0500;
        chan_event <= 12'h084;
        wt(4);
        `CHK({primary_fault_pin_oe, secondary_fault_pin_oe, alarm_out_a_oe}, 3'b111)
        chan_event <= 12'h000;
        nvm_check_ok <= 1'b0;
        wt(4);
        `CHK({primary_fault_pin_oe, secondary_fault_pin_oe, alarm_out_a_oe}, 3'b110)
        $display("test inert done");
        end_sim;
    end
endmodule
